// file: rtl/mwm_pkg.sv
// Purpose: Constants and types for the memory window and map checker
// Assumes: 32-bit addresses, sixteen regions of 28-bit span
// Notes:   Register offsets for the plain register port live here
package mwm_pkg;
    localparam int          ADDR_W        = 32;
    localparam int          NUM_WIN       = 8;
    localparam int          ALIGN_BITS    = 6;
    localparam int          REGION_BITS   = 4;
    localparam int          OFFSET_W      = 28;
    localparam int          KB_SHIFT      = 10;
    localparam logic [5:0]  ALIGN_ZERO    = 6'h00;
    localparam logic [5:0]  ALIGN_ONES    = 6'h3F;

    // Register port map (word addresses)
    localparam logic [7:0]  REG_STATUS    = 8'h00;
    localparam logic [7:0]  REG_ADDR      = 8'h01;
    localparam logic [7:0]  REG_RESULT    = 8'h02;
    localparam logic [7:0]  REG_CTRL      = 8'h03;
    localparam logic [7:0]  REG_IF_EN     = 8'h04;
    localparam logic [7:0]  REG_LS_EN     = 8'h05;
    localparam logic [7:0]  REG_IF_BASE0  = 8'h10;
    localparam logic [7:0]  REG_IF_MASK0  = 8'h18;
    localparam logic [7:0]  REG_LS_BASE0  = 8'h20;
    localparam logic [7:0]  REG_LS_MASK0  = 8'h28;
    localparam logic [7:0]  WIN_IDX_MASK  = 8'hF8;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
    localparam logic [31:0] RST_BASE      = 32'h0000_0000;
    localparam logic [31:0] RST_MASK      = 32'h0000_003F;

    // Result word bit positions
    localparam int          RES_IF_HIT    = 0;
    localparam int          RES_LS_HIT    = 1;
    localparam int          RES_IMEM      = 2;
    localparam int          RES_DMEM      = 3;
    localparam int          RES_INTC      = 4;
    localparam int          RES_CACHE_ECC = 5;

    typedef struct packed {
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] mask;
        logic              enable;
    } mwm_window_type;

    typedef struct packed {
        logic              if_hit;
        logic              ls_hit;
        logic              imem_sel;
        logic              dmem_sel;
        logic              intc_sel;
    } mwm_route_type;

    // Round a size in KB up to a power of two and return a byte span
    function automatic logic [31:0] mwm_span_bytes(input int size_kb);
        int p;
        p = 1;
        while (p < size_kb) p = p * 2;
        return 32'(p) << KB_SHIFT;
    endfunction
endpackage

// file: rtl/mwm_top.sv
// Purpose: Access window protection and local memory map decode
// Assumes: Inputs synchronous to ref_clk_i; placement fixed by parameters
// Notes:   Windows are writable through the register port; illegal values flagged
`timescale 1ns/1ns
module mwm_top
    import mwm_pkg::*;
#(
    parameter bit          IMEM_LOCAL_PRESENT = 1'b1,
    parameter int          IMEM_LOCAL_REGION  = 14,
    parameter logic [27:0] IMEM_LOCAL_OFFSET  = 28'h000_0000,
    parameter int          IMEM_LOCAL_SIZE    = 64,
    parameter int          DMEM_LOCAL_REGION  = 15,
    parameter logic [27:0] DMEM_LOCAL_OFFSET  = 28'h004_0000,
    parameter int          DMEM_LOCAL_SIZE    = 64,
    parameter bit          ICACHE_PRESENT     = 1'b1,
    parameter int          ICACHE_SIZE_KB     = 16,
    parameter bit          ICACHE_PROTECT_SEL = 1'b0,
    parameter int          INTC_REGS_REGION   = 15,
    parameter logic [27:0] INTC_REGS_OFFSET   = 28'h00C_0000,
    parameter int          INTC_REGS_SIZE     = 32
) (
    input  wire logic        ref_clk_i,    // Core clock
    input  wire logic        sys_rst_i,    // Synchronous reset, high
    input  wire logic        fetch_req_i,  // Fetch address valid
    input  wire logic [31:0] fetch_addr_i, // Fetch address
    input  wire logic        ldst_req_i,   // Load/store address valid
    input  wire logic [31:0] ldst_addr_i,  // Load/store address
    input  wire logic [7:0]  reg_addr_i,   // Register word address
    input  wire logic [31:0] reg_wdata_i,  // Register write data
    input  wire logic        reg_wr_i,     // Register write strobe
    input  wire logic        reg_rd_i,     // Register read strobe
    output logic      [31:0] reg_rdata_o,  // Read data, cycle after strobe
    output logic             fetch_hit_o,  // Fetch inside an enabled window
    output logic             fetch_imem_o, // Fetch routed to instr local memory
    output logic             fetch_fault_o,// Fetch in no enabled legal window
    output logic             ldst_hit_o,   // Load/store inside an enabled window
    output logic             ldst_dmem_o,  // Load/store routed to data local memory
    output logic             ldst_intc_o,  // Load/store routed to interrupt block
    output logic             ldst_fault_o, // Load/store in no enabled legal window
    output logic             cfg_err_o     // Window or placement setting illegal
);

    ////////////////////////////////////////////////////////////////////////////
    // Fixed placement checks

    localparam logic [31:0] IMEM_SPAN = mwm_span_bytes(IMEM_LOCAL_SIZE);
    localparam logic [31:0] DMEM_SPAN = mwm_span_bytes(DMEM_LOCAL_SIZE);
    localparam logic [31:0] INTC_SPAN = mwm_span_bytes(INTC_REGS_SIZE);
    localparam logic [31:0] IMEM_BASE = {4'(IMEM_LOCAL_REGION), IMEM_LOCAL_OFFSET};
    localparam logic [31:0] DMEM_BASE = {4'(DMEM_LOCAL_REGION), DMEM_LOCAL_OFFSET};
    localparam logic [31:0] INTC_BASE = {4'(INTC_REGS_REGION), INTC_REGS_OFFSET};
    localparam logic [32:0] REGION_SPAN = 33'h1_0000_0000 >> REGION_BITS;

    localparam bit IMEM_SIZE_OK = (IMEM_LOCAL_SIZE inside
                                   {4, 8, 16, 32, 64, 128, 256, 512});
    localparam bit DMEM_SIZE_OK = (DMEM_LOCAL_SIZE inside
                                   {4, 8, 16, 32, 48, 64, 128, 256, 512});
    localparam bit ICACHE_OK    = !ICACHE_PRESENT ||
                                  (ICACHE_SIZE_KB inside {16, 32, 64, 128, 256});
    localparam bit INTC_SIZE_OK = (INTC_REGS_SIZE inside {32, 64, 128, 256});
    localparam bit REGIONS_OK   = (IMEM_LOCAL_REGION < 16) && (DMEM_LOCAL_REGION < 16) &&
                                  (INTC_REGS_REGION < 16);

    // Offset multiple of own span, and end stays inside the region
    localparam bit IMEM_ALN = ((32'(IMEM_LOCAL_OFFSET) & (IMEM_SPAN - 1)) == 0) &&
                              (33'(IMEM_LOCAL_OFFSET) + 33'(IMEM_SPAN) <= REGION_SPAN);
    localparam bit DMEM_ALN = ((32'(DMEM_LOCAL_OFFSET) & (DMEM_SPAN - 1)) == 0) &&
                              (33'(DMEM_LOCAL_OFFSET) + 33'(DMEM_SPAN) <= REGION_SPAN);
    localparam bit INTC_ALN = ((32'(INTC_REGS_OFFSET) & (INTC_SPAN - 1)) == 0) &&
                              (33'(INTC_REGS_OFFSET) + 33'(INTC_SPAN) <= REGION_SPAN);

    // Naturally aligned blocks overlap exactly when one base falls in the other
    localparam bit OV_ID = IMEM_LOCAL_PRESENT &&
        (((IMEM_BASE & ~(DMEM_SPAN - 1)) == DMEM_BASE) ||
         ((DMEM_BASE & ~(IMEM_SPAN - 1)) == IMEM_BASE));
    localparam bit OV_IP = IMEM_LOCAL_PRESENT &&
        (((IMEM_BASE & ~(INTC_SPAN - 1)) == INTC_BASE) ||
         ((INTC_BASE & ~(IMEM_SPAN - 1)) == IMEM_BASE));
    localparam bit OV_DP = ((DMEM_BASE & ~(INTC_SPAN - 1)) == INTC_BASE) ||
                           ((INTC_BASE & ~(DMEM_SPAN - 1)) == DMEM_BASE);

    localparam bit MAP_OK = (!IMEM_LOCAL_PRESENT || (IMEM_SIZE_OK && IMEM_ALN)) &&
                            DMEM_SIZE_OK && DMEM_ALN && INTC_SIZE_OK && INTC_ALN &&
                            ICACHE_OK && REGIONS_OK && !OV_ID && !OV_IP && !OV_DP;

    ////////////////////////////////////////////////////////////////////////////
    // Window storage

    mwm_window_type if_win_q [NUM_WIN];
    mwm_window_type ls_win_q [NUM_WIN];
    logic [31:0]    probe_addr_q;
    logic [31:0]    reg_rdata_q;
    logic           fetch_hit_q;
    logic           fetch_imem_q;
    logic           fetch_fault_q;
    logic           ldst_hit_q;
    logic           ldst_dmem_q;
    logic           ldst_intc_q;
    logic           ldst_fault_q;
    logic           cfg_err_q;

    logic [NUM_WIN-1:0] if_legal;
    logic [NUM_WIN-1:0] ls_legal;
    logic [NUM_WIN-1:0] if_match;
    logic [NUM_WIN-1:0] ls_match;
    logic [NUM_WIN-1:0] if_probe;
    logic [NUM_WIN-1:0] ls_probe;

    wire [2:0] wr_idx     = reg_addr_i[2:0];
    wire [7:0] wr_grp     = reg_addr_i & WIN_IDX_MASK;
    wire       wr_if_base = reg_wr_i && (wr_grp == REG_IF_BASE0);
    wire       wr_if_mask = reg_wr_i && (wr_grp == REG_IF_MASK0);
    wire       wr_ls_base = reg_wr_i && (wr_grp == REG_LS_BASE0);
    wire       wr_ls_mask = reg_wr_i && (wr_grp == REG_LS_MASK0);
    wire       wr_if_en   = reg_wr_i && (reg_addr_i == REG_IF_EN);
    wire       wr_ls_en   = reg_wr_i && (reg_addr_i == REG_LS_EN);
    wire       wr_probe   = reg_wr_i && (reg_addr_i == REG_ADDR);

    // Legal check: low bits, contiguous mask, no shared ones
    function automatic logic win_legal(input mwm_window_type w);
        logic [31:0] m1;
        m1 = w.mask + 32'h0000_0001;
        return (w.base[ALIGN_BITS-1:0] == ALIGN_ZERO) &&
               (w.mask[ALIGN_BITS-1:0] == ALIGN_ONES) &&
               ((w.mask & m1) == ZERO_WORD) &&
               ((w.base & w.mask) == ZERO_WORD);
    endfunction

    function automatic logic win_hit(input mwm_window_type w, input logic [31:0] a);
        return w.enable && ((a | w.mask) == (w.base | w.mask));
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_WIN; g++) begin : g_win
            assign if_legal[g] = !if_win_q[g].enable || win_legal(if_win_q[g]);
            assign ls_legal[g] = !ls_win_q[g].enable || win_legal(ls_win_q[g]);
            // Illegal windows never grant access, so a bad setting fails closed
            assign if_match[g] = win_hit(if_win_q[g], fetch_addr_i) && if_legal[g];
            assign ls_match[g] = win_hit(ls_win_q[g], ldst_addr_i) && ls_legal[g];
            assign if_probe[g] = win_hit(if_win_q[g], probe_addr_q) && if_legal[g];
            assign ls_probe[g] = win_hit(ls_win_q[g], probe_addr_q) && ls_legal[g];

            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i) begin
                    if_win_q[g] <= '{base: RST_BASE, mask: RST_MASK, enable: 1'b0};
                    ls_win_q[g] <= '{base: RST_BASE, mask: RST_MASK, enable: 1'b0};
                end else begin
                    if (wr_if_base && wr_idx == 3'(g)) if_win_q[g].base <= reg_wdata_i;
                    if (wr_if_mask && wr_idx == 3'(g)) if_win_q[g].mask <= reg_wdata_i;
                    if (wr_if_en) if_win_q[g].enable <= reg_wdata_i[g];
                    if (wr_ls_base && wr_idx == 3'(g)) ls_win_q[g].base <= reg_wdata_i;
                    if (wr_ls_mask && wr_idx == 3'(g)) ls_win_q[g].mask <= reg_wdata_i;
                    if (wr_ls_en) ls_win_q[g].enable <= reg_wdata_i[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Map decode

    function automatic logic blk_sel(input logic [31:0] a, input logic [31:0] base,
                                     input logic [31:0] span);
        return (a[31:OFFSET_W] == base[31:OFFSET_W]) &&
               ((a[OFFSET_W-1:0] & ~span[OFFSET_W-1:0] + 28'h1) ==
                (base[OFFSET_W-1:0] & ~span[OFFSET_W-1:0] + 28'h1));
    endfunction

    wire imem_f = IMEM_LOCAL_PRESENT && MAP_OK && blk_sel(fetch_addr_i, IMEM_BASE, IMEM_SPAN);
    wire dmem_l = MAP_OK && blk_sel(ldst_addr_i, DMEM_BASE, DMEM_SPAN);
    wire intc_l = MAP_OK && blk_sel(ldst_addr_i, INTC_BASE, INTC_SPAN);
    wire imem_p = IMEM_LOCAL_PRESENT && blk_sel(probe_addr_q, IMEM_BASE, IMEM_SPAN);
    wire dmem_p = blk_sel(probe_addr_q, DMEM_BASE, DMEM_SPAN);
    wire intc_p = blk_sel(probe_addr_q, INTC_BASE, INTC_SPAN);

    wire if_any   = |if_match;
    wire ls_any   = |ls_match;
    wire win_bad  = !(&if_legal) || !(&ls_legal);
    wire [31:0] status_w = {30'h0000_0000, !MAP_OK, win_bad};
    wire [31:0] result_w = {26'h000_0000, ICACHE_PROTECT_SEL, intc_p, dmem_p, imem_p,
                            |ls_probe, |if_probe};
    wire [31:0] if_en_w  = {24'h00_0000, if_win_q[7].enable, if_win_q[6].enable,
                            if_win_q[5].enable, if_win_q[4].enable, if_win_q[3].enable,
                            if_win_q[2].enable, if_win_q[1].enable, if_win_q[0].enable};
    wire [31:0] ls_en_w  = {24'h00_0000, ls_win_q[7].enable, ls_win_q[6].enable,
                            ls_win_q[5].enable, ls_win_q[4].enable, ls_win_q[3].enable,
                            ls_win_q[2].enable, ls_win_q[1].enable, ls_win_q[0].enable};
    wire [31:0] ctrl_w   = {30'h0000_0000, ICACHE_PROTECT_SEL, ICACHE_PRESENT};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = ZERO_WORD;
        if (reg_addr_i == REG_STATUS) rd_mux = status_w;
        else if (reg_addr_i == REG_ADDR) rd_mux = probe_addr_q;
        else if (reg_addr_i == REG_RESULT) rd_mux = result_w;
        else if (reg_addr_i == REG_CTRL) rd_mux = ctrl_w;
        else if (reg_addr_i == REG_IF_EN) rd_mux = if_en_w;
        else if (reg_addr_i == REG_LS_EN) rd_mux = ls_en_w;
        else if (wr_grp == REG_IF_BASE0) rd_mux = if_win_q[wr_idx].base;
        else if (wr_grp == REG_IF_MASK0) rd_mux = if_win_q[wr_idx].mask;
        else if (wr_grp == REG_LS_BASE0) rd_mux = ls_win_q[wr_idx].base;
        else if (wr_grp == REG_LS_MASK0) rd_mux = ls_win_q[wr_idx].mask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers, one cycle after the request

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            probe_addr_q  <= ZERO_WORD;
            reg_rdata_q   <= ZERO_WORD;
            fetch_hit_q   <= 1'b0;
            fetch_imem_q  <= 1'b0;
            fetch_fault_q <= 1'b0;
            ldst_hit_q    <= 1'b0;
            ldst_dmem_q   <= 1'b0;
            ldst_intc_q   <= 1'b0;
            ldst_fault_q  <= 1'b0;
            cfg_err_q     <= 1'b0;
        end else begin
            if (wr_probe) probe_addr_q <= reg_wdata_i;
            reg_rdata_q   <= reg_rd_i ? rd_mux : ZERO_WORD;
            fetch_hit_q   <= fetch_req_i && if_any;
            fetch_imem_q  <= fetch_req_i && imem_f;
            fetch_fault_q <= fetch_req_i && !if_any;
            ldst_hit_q    <= ldst_req_i && ls_any;
            ldst_dmem_q   <= ldst_req_i && dmem_l;
            ldst_intc_q   <= ldst_req_i && intc_l;
            ldst_fault_q  <= ldst_req_i && !ls_any;
            cfg_err_q     <= win_bad || !MAP_OK;
        end
    end

    assign reg_rdata_o   = reg_rdata_q;
    assign fetch_hit_o   = fetch_hit_q;
    assign fetch_imem_o  = fetch_imem_q;
    assign fetch_fault_o = fetch_fault_q;
    assign ldst_hit_o    = ldst_hit_q;
    assign ldst_dmem_o   = ldst_dmem_q;
    assign ldst_intc_o   = ldst_intc_q;
    assign ldst_fault_o  = ldst_fault_q;
    assign cfg_err_o     = cfg_err_q;

endmodule

// file: testbench/mwm_top_sva.sv
// Purpose: Port-level checks on window hits and local block routing
// Assumes: Placement parameters legal, as the bench instantiates them
// Notes:   Bound to every mwm_top instance
`timescale 1ns/1ns
module mwm_top_chk
    import mwm_pkg::*;
#(
    parameter int          IMEM_LOCAL_REGION = 14,
    parameter logic [27:0] IMEM_LOCAL_OFFSET = 28'h000_0000,
    parameter int          IMEM_LOCAL_SIZE   = 64,
    parameter int          DMEM_LOCAL_REGION = 15,
    parameter logic [27:0] DMEM_LOCAL_OFFSET = 28'h004_0000,
    parameter int          DMEM_LOCAL_SIZE   = 64,
    parameter int          INTC_REGS_REGION  = 15,
    parameter logic [27:0] INTC_REGS_OFFSET  = 28'h00C_0000,
    parameter int          INTC_REGS_SIZE    = 32
) (
    input wire logic        ref_clk_i,     // Core clock
    input wire logic        sys_rst_i,     // Synchronous reset
    input wire logic        fetch_req_i,   // Fetch valid
    input wire logic [31:0] fetch_addr_i,  // Fetch address
    input wire logic        ldst_req_i,    // Load/store valid
    input wire logic [31:0] ldst_addr_i,   // Load/store address
    input wire logic        reg_wr_i,      // Register write strobe
    input wire logic        fetch_hit_o,   // Fetch window hit
    input wire logic        fetch_imem_o,  // Fetch to instr memory
    input wire logic        fetch_fault_o, // Fetch fault
    input wire logic        ldst_hit_o,    // Load/store window hit
    input wire logic        ldst_dmem_o,   // Load/store to data memory
    input wire logic        ldst_intc_o,   // Load/store to interrupt block
    input wire logic        ldst_fault_o,  // Load/store fault
    input wire logic        cfg_err_o      // Setting illegal
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Wrapping subtraction makes addresses below the block fall out too
    function automatic bit in_blk(input logic [31:0] a, input int rg,
                                  input logic [27:0] off, input int kb);
        return a[31:28] == rg[3:0] && (a[27:0] - off) < (28'(kb) << KB_SHIFT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    a_fetch_excl: assert property ($past(fetch_req_i) && !$past(sys_rst_i)
        |-> fetch_hit_o ^ fetch_fault_o) else $error("fetch hit and fault clash");
    a_ldst_excl: assert property ($past(ldst_req_i) && !$past(sys_rst_i)
        |-> ldst_hit_o ^ ldst_fault_o) else $error("ldst hit and fault clash");
    a_fetch_quiet: assert property (!$past(fetch_req_i)
        |-> !fetch_hit_o && !fetch_fault_o && !fetch_imem_o) else $error("fetch result unasked");
    a_ldst_quiet: assert property (!$past(ldst_req_i)
        |-> !ldst_hit_o && !ldst_fault_o && !ldst_dmem_o && !ldst_intc_o)
        else $error("ldst result unasked");
    a_imem_route: assert property ($past(fetch_req_i) && !$past(sys_rst_i)
        |-> fetch_imem_o == in_blk($past(fetch_addr_i), IMEM_LOCAL_REGION,
                                   IMEM_LOCAL_OFFSET, IMEM_LOCAL_SIZE))
        else $error("instr memory decode wrong");
    a_dmem_route: assert property ($past(ldst_req_i) && !$past(sys_rst_i)
        |-> ldst_dmem_o == in_blk($past(ldst_addr_i), DMEM_LOCAL_REGION,
                                  DMEM_LOCAL_OFFSET, DMEM_LOCAL_SIZE))
        else $error("data memory decode wrong");
    a_intc_route: assert property ($past(ldst_req_i) && !$past(sys_rst_i)
        |-> ldst_intc_o == in_blk($past(ldst_addr_i), INTC_REGS_REGION,
                                  INTC_REGS_OFFSET, INTC_REGS_SIZE))
        else $error("interrupt block decode wrong");
    a_err_cause: assert property ($changed(cfg_err_o) && !$past(sys_rst_i)
        && !$past(sys_rst_i, 2) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
        else $error("setting error moved without a write");
endmodule

bind mwm_top mwm_top_chk #(
    .IMEM_LOCAL_REGION (IMEM_LOCAL_REGION), .IMEM_LOCAL_OFFSET (IMEM_LOCAL_OFFSET),
    .IMEM_LOCAL_SIZE   (IMEM_LOCAL_SIZE),   .DMEM_LOCAL_REGION (DMEM_LOCAL_REGION),
    .DMEM_LOCAL_OFFSET (DMEM_LOCAL_OFFSET), .DMEM_LOCAL_SIZE   (DMEM_LOCAL_SIZE),
    .INTC_REGS_REGION  (INTC_REGS_REGION),  .INTC_REGS_OFFSET  (INTC_REGS_OFFSET),
    .INTC_REGS_SIZE    (INTC_REGS_SIZE)
) u_mwm_top_chk (
    .ref_clk_i (ref_clk_i), .sys_rst_i (sys_rst_i), .fetch_req_i (fetch_req_i),
    .fetch_addr_i (fetch_addr_i), .ldst_req_i (ldst_req_i), .ldst_addr_i (ldst_addr_i),
    .reg_wr_i (reg_wr_i), .fetch_hit_o (fetch_hit_o), .fetch_imem_o (fetch_imem_o),
    .fetch_fault_o (fetch_fault_o), .ldst_hit_o (ldst_hit_o), .ldst_dmem_o (ldst_dmem_o),
    .ldst_intc_o (ldst_intc_o), .ldst_fault_o (ldst_fault_o), .cfg_err_o (cfg_err_o)
);

// file: testbench/mwm_core_model.sv
// Purpose: Fetch and load/store units presenting addresses to the checker
// Assumes: One request cycle per call
// Notes:   Idle address lines show the inverse of the last address
`timescale 1ns/1ns
module mwm_core_model (
    input  wire logic        ref_clk_i,    // Core clock
    output logic             fetch_req_o,  // Fetch address valid
    output logic      [31:0] fetch_addr_o, // Fetch address
    output logic             ldst_req_o,   // Load/store address valid
    output logic      [31:0] ldst_addr_o   // Load/store address
);
    initial begin
        fetch_req_o  = 1'b0;
        ldst_req_o   = 1'b0;
        fetch_addr_o = 32'h0000_0000;
        ldst_addr_o  = 32'h0000_0000;
    end

    task automatic issue(input logic [31:0] fa, input logic [31:0] la);
        @(posedge ref_clk_i);
        fetch_req_o  <= 1'b1;
        fetch_addr_o <= fa;
        ldst_req_o   <= 1'b1;
        ldst_addr_o  <= la;
        @(posedge ref_clk_i);
        fetch_req_o  <= 1'b0;
        ldst_req_o   <= 1'b0;
        // A stale address must never look like a fresh request
        fetch_addr_o <= ~fa;
        ldst_addr_o  <= ~la;
    endtask
endmodule

// file: testbench/mwm_top_bench.sv
// Purpose: Self-checking bench for window protection and map decode
// Assumes: Default placement; windows programmed through the register port
// Notes:   Model windows 0..7 fetch side, 8..15 load/store side
`timescale 1ns/1ns
module mwm_top_bench;
    import mwm_pkg::*;
    logic ref_clk_i, sys_rst_i, fetch_req_i, ldst_req_i, reg_wr_i, reg_rd_i;
    logic fetch_hit_o, fetch_imem_o, fetch_fault_o, ldst_hit_o, ldst_dmem_o;
    logic ldst_intc_o, ldst_fault_o, cfg_err_o;
    logic [31:0] fetch_addr_i, ldst_addr_i, reg_wdata_i, reg_rdata_o, rd, b, m;
    logic [7:0]  reg_addr_i;
    logic [31:0] wb [16];
    logic [31:0] wm [16];
    logic [15:0] we;
    int          errors, n_tests;
    mwm_top u_mwm_top (.ref_clk_i, .sys_rst_i, .fetch_req_i, .fetch_addr_i, .ldst_req_i,
        .ldst_addr_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .fetch_hit_o, .fetch_imem_o, .fetch_fault_o, .ldst_hit_o, .ldst_dmem_o,
        .ldst_intc_o, .ldst_fault_o, .cfg_err_o);
    mwm_core_model u_mwm_core_model (.ref_clk_i (ref_clk_i), .fetch_req_o (fetch_req_i),
        .fetch_addr_o (fetch_addr_i), .ldst_req_o (ldst_req_i), .ldst_addr_o (ldst_addr_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic bit legal(input logic [31:0] b, input logic [31:0] m);
        return b[5:0] == ALIGN_ZERO && m[5:0] == ALIGN_ONES && (m & (m + 32'h1)) == 0
            && (b & m) == 0;
    endfunction
    function automatic bit hit(input logic [31:0] a, input int s);
        for (int i = s; i < s + 8; i++)
            if (we[i] && legal(wb[i], wm[i]) && (a | wm[i]) == (wb[i] | wm[i])) return 1;
        return 0;
    endfunction
    function automatic bit any_bad();
        for (int i = 0; i < 16; i++) if (we[i] && !legal(wb[i], wm[i])) return 1;
        return 0;
    endfunction
    function automatic bit in_blk(input logic [31:0] a, input logic [31:0] lo, input int kb);
        return a >= lo && a - lo < (32'(kb) << KB_SHIFT);
    endfunction
    task automatic check_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s is %b", $time, what, got);
        end
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b0;
        @(negedge ref_clk_i);
        d = reg_rdata_o;
    endtask
    task automatic set_win(input int i, input logic [31:0] b, input logic [31:0] m,
                           input logic e);
        logic [7:0] a;
        a = (i < 8) ? REG_IF_BASE0 + 8'(i) : REG_LS_BASE0 + 8'(i - 8);
        wb[i] = b;
        wm[i] = m;
        we[i] = e;
        reg_wr(a, b);
        reg_wr(a + 8'h08, m);
        reg_wr(REG_IF_EN, {24'h0, we[7:0]});
        reg_wr(REG_LS_EN, {24'h0, we[15:8]});
        reg_rd(REG_STATUS, rd);
        check_word(rd, {31'h0, any_bad()});
        check_bit(cfg_err_o, any_bad(), "setting error");
    endtask
    task automatic probe(input logic [31:0] fa, input logic [31:0] la);
        logic im, dm, ic;
        u_mwm_core_model.issue(fa, la);
        @(negedge ref_clk_i);
        check_bit(fetch_hit_o, hit(fa, 0), "fetch hit");
        check_bit(fetch_fault_o, !hit(fa, 0), "fetch fault");
        check_bit(fetch_imem_o, in_blk(fa, 32'hE000_0000, 64), "imem");
        check_bit(ldst_hit_o, hit(la, 8), "ldst hit");
        check_bit(ldst_fault_o, !hit(la, 8), "ldst fault");
        check_bit(ldst_dmem_o, in_blk(la, 32'hF004_0000, 64), "dmem");
        check_bit(ldst_intc_o, in_blk(la, 32'hF00C_0000, 32), "intc");
        im = in_blk(fa, 32'hE000_0000, 64);
        dm = in_blk(fa, 32'hF004_0000, 64);
        ic = in_blk(fa, 32'hF00C_0000, 32);
        reg_wr(REG_ADDR, fa);
        reg_rd(REG_RESULT, rd);
        check_word(rd, {26'h0, 1'b0, ic, dm, im, hit(fa, 8), hit(fa, 0)});
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        end_of_test();
    end
    initial begin
        logic [31:0] tbl [10];
        sys_rst_i = 1'b1;
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
        {errors, n_tests, we} = '0;
        for (int i = 0; i < 16; i++) {wb[i], wm[i]} = {RST_BASE, RST_MASK};
        tbl = '{32'hE000_0000, 32'hE000_FFFF, 32'hE001_0000, 32'hDFFF_FFFF, 32'hF004_0000,
                32'hF004_FFFF, 32'hF003_FFFF, 32'hF00C_0000, 32'hF00C_7FFF, 32'hF00C_8000};
        void'($urandom(32'hFA03));
        repeat (12) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        for (int a = 8'h10; a < 8'h30; a++) begin
            reg_rd(8'(a), rd);
            check_word(rd, (a & 8) ? RST_MASK : RST_BASE);
        end
        reg_rd(REG_CTRL, rd);
        check_word(rd, 32'h0000_0001);
        reg_rd(REG_STATUS, rd);
        check_word(rd, ZERO_WORD);
        reg_rd(8'h40, rd);
        check_word(rd, ZERO_WORD);
        foreach (tbl[i]) probe(tbl[i], tbl[i]);
        // Base bit 5 set, mask low bit clear, mask with a hole, base inside mask
        set_win(7, 32'h0000_0020, 32'h0000_003F, 1'b1);
        probe(32'h0000_0020, 32'h0000_0020);
        set_win(7, 32'h0000_0000, 32'h0000_007E, 1'b1);
        set_win(7, 32'h0000_0000, 32'h0000_013F, 1'b1);
        probe(32'h0000_0100, 32'h0000_0100);
        set_win(7, 32'h0000_0040, 32'h0000_007F, 1'b1);
        probe(32'h0000_0040, 32'h0000_0040);
        set_win(7, RST_BASE, RST_MASK, 1'b0);
        for (int n = 0; n < 32; n++) begin
            m = 32'hFFFF_FFFF >> (32 - $urandom_range(31, 6));
            b = $urandom & ~m;
            set_win(n % 16, b, m, n < 16 || $urandom_range(1, 0));
            probe(b | ($urandom & m), b | m);
            probe($urandom, (b | m) + 32'h1);
        end
        end_of_test();
    end
endmodule
